// ---- verilog/dbs_pkg.sv ----
// Shared constants for the dual battery selector link: I2C device end and host end.
// Assumes both ends run on the same 40 MHz aclk.
package dbs_pkg;
   // Clock and timing
   localparam int CLK_NS         = 25;
   localparam int QUAL_DELAY_NS  = 2000000;                    // Threshold-one qualification
   localparam int QUAL_CYCLES    = QUAL_DELAY_NS / CLK_NS;     // Typical, rounded down
   localparam int I2C_QTR_NS     = 2500;                       // Quarter of a 100 kHz bit
   localparam int I2C_QTR_CYCLES = I2C_QTR_NS / CLK_NS;

   // Device slave address, upper five bits
   localparam logic [4:0] DEV_ADDR_HI = 5'h17;

   // Device register map
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CONFIG = 8'h01;
   localparam logic [7:0] REG_RESET  = 8'h0f;
   localparam logic [7:0] RESET_KEY  = 8'h00;
   localparam logic [5:0] CFG_RESET  = 6'h00;
   localparam logic       CHG_RESET  = 1'h0;

   // Configuration field positions
   localparam int CFG_CHG = 6;
   localparam int CFG_SEL = 4;
   localparam int CFG_HYS = 2;
   localparam int CFG_TH1 = 1;
   localparam int CFG_TH2 = 0;

   // Power select and supply source codes
   localparam logic [1:0] SEL_AUTO = 2'h0;
   localparam logic [1:0] SEL_A    = 2'h1;
   localparam logic [1:0] SEL_B    = 2'h2;
   localparam logic [1:0] SRC_A    = 2'h0;
   localparam logic [1:0] SRC_B    = 2'h1;
   localparam logic [1:0] SRC_AC   = 2'h3;

   // Comparator vector bit positions, each high when at or above the level
   localparam int CMP_TH2  = 0;
   localparam int CMP_TH1  = 1;
   localparam int CMP_TH1H = 2;
   localparam int CMP_FULL = 3;

   // Host AXI4-Lite map
   localparam int         AXI_AW      = 8;
   localparam logic [7:0] AXI_CTRL    = 8'h00;
   localparam logic [7:0] AXI_STATUS  = 8'h04;
   localparam int         CTRL_GO     = 0;
   localparam int         CTRL_RD     = 1;
   localparam int         CTRL_REG    = 8;
   localparam int         CTRL_WDATA  = 16;
   localparam int         CTRL_STRAP  = 24;
   localparam int         STAT_BUSY   = 0;
   localparam int         STAT_NACK   = 1;
   localparam int         STAT_RDATA  = 8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- verilog/dbs_if.sv ----
// Two-wire link between host end and device end.
// Both data drivers are open drain; the pull-up is modelled here.
interface dbs_if;
   logic scl;
   logic host_sda_oe;
   logic host_sda_out;
   logic dev_sda_oe;
   logic dev_sda_out;
   wire  sda;

   // Wired-AND of both drivers with pull-up
   assign sda = ((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out)) ? 1'b0 : 1'b1;

   modport host (output scl, output host_sda_oe, output host_sda_out, input sda);
   modport device (input scl, input sda, output dev_sda_oe, output dev_sda_out);
endinterface

// ---- verilog/dbs_device.sv ----
// Device end: I2C slave registers plus discharge-mode supply selection.
// Assumes comparator, id and charger-status inputs come from analog, asynchronous.
//
// Summary of operation
// - Address 10111 plus two strap pin levels
// - Address LSB: 0 write, 1 read
// - Data sampled only while clock high
// - Acknowledge matching address, master stops on none
// - Command then data, MSB first, each acknowledged
// - Command byte selects register for write data
// - Read: command, repeated start, return selected register
// - Register 00h read-only live battery status
// - Bits 7/6 high when battery absent
// - Bits 5:4 supply source A, B, adapter
// - Per-battery voltage band two-bit codes
// - Register 01h configuration, writable fields reset zero
// - Config bit 7 reads charger B status
// - Bit 6 reads A status, writes charger off
// - Power select auto/A/B, forced needs both above two
// - Hysteresis select field in bits 3:2
// - Bits 1/0 select threshold one/two
// - Zero written to 0Fh restores defaults
// - A low, B above two: switch B immediately
// - A below one for delay, B high: B
// - Otherwise A stays supply, always if B low
// - Forced battery below two: automatic until recovered
// - Qualification delay two milliseconds
//
// Local design decision: register access over AXI4-Lite.
module dbs_device
   import dbs_pkg::*;
#(
   parameter int QUAL = QUAL_CYCLES
) (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Serial link
   dbs_if.device           bus,
   // Straps and battery sense
   input  wire logic       addr_strap_high,
   input  wire logic       addr_strap_low,
   input  wire logic       battery_a_id_input,
   input  wire logic       battery_b_id_input,
   input  wire logic       adapter_present,
   input  wire logic [3:0] batt_a_cmp,
   input  wire logic [3:0] batt_b_cmp,
   input  wire logic       batt_a_charge_status,
   input  wire logic       batt_b_charge_status,
   // Analog controls
   output logic      [1:0] supply_source_state,
   output logic            threshold_one,
   output logic            threshold_two,
   output logic      [1:0] hysteresis_select,
   output logic            charger_off
);
   if (QUAL < 1) $error("QUAL must be at least one cycle");

   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_CMD, S_WDATA, S_RDATA} dbs_dev_state_t;

   localparam int QW = $clog2(QUAL + 1);

   // Two-stage synchroniser on every asynchronous input
   logic [16:0] sync1;
   logic [16:0] sync2;
   logic        scl_q;
   logic        sda_q;
   always_ff @(posedge aclk) begin
      sync1 <= {bus.scl, bus.sda, addr_strap_high, addr_strap_low, battery_a_id_input,
                battery_b_id_input, adapter_present, batt_a_cmp, batt_b_cmp,
                batt_a_charge_status, batt_b_charge_status};
      sync2 <= sync1;
      scl_q <= sync2[16];
      sda_q <= sync2[15];
   end

   wire       scl     = sync2[16];
   wire       sda     = sync2[15];
   wire [1:0] strap   = sync2[14:13];
   wire       a_id    = sync2[12];
   wire       b_id    = sync2[11];
   wire       adapter = sync2[10];
   wire [3:0] a_cmp   = sync2[9:6];
   wire [3:0] b_cmp   = sync2[5:2];
   wire       a_chg   = sync2[1];
   wire       b_chg   = sync2[0];

   // Bus conditions, data changes only count while clock high
   wire start_c = scl & scl_q & sda_q & ~sda;
   wire stop_c  = scl & scl_q & ~sda_q & sda;
   wire scl_up  = scl & ~scl_q;
   wire scl_dn  = ~scl & scl_q;

   // Register contents
   logic [5:0] cfg;
   logic       chg_off;
   logic [1:0] src;
   wire  [1:0] pwr_sel = cfg[CFG_SEL+1:CFG_SEL];

   // Voltage bands from comparators
   wire [1:0] a_band = a_cmp[CMP_FULL] ? 2'h3 : a_cmp[CMP_TH1] ? 2'h2 :
                       a_cmp[CMP_TH2] ? 2'h1 : 2'h0;
   wire [1:0] b_band = b_cmp[CMP_FULL] ? 2'h3 : b_cmp[CMP_TH1] ? 2'h2 :
                       b_cmp[CMP_TH2] ? 2'h1 : 2'h0;
   wire [7:0] status_val = {~b_id, ~a_id, src, b_band, a_band};
   wire [7:0] config_val = {b_chg, a_chg, cfg};
   wire [7:0] rd_val;

   // I2C slave state
   dbs_dev_state_t st;
   logic [3:0]     cnt;
   logic [7:0]     shift;
   logic [7:0]     ptr;
   logic [7:0]     tx;
   logic           nack;
   logic           oe;

   wire [7:0] rx_byte   = shift;
   wire       addr_hit  = rx_byte[7:1] == {DEV_ADDR_HI, strap};
   wire       wr_cfg    = ptr == REG_CONFIG;
   wire       wr_rst    = (ptr == REG_RESET) && (rx_byte == RESET_KEY);
   assign rd_val = (ptr == REG_STATUS) ? status_val :
                   (ptr == REG_CONFIG) ? config_val : 8'h00;

   // Serial engine: shift on rising clock, drive on falling clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st    <= S_IDLE;
         cnt   <= 4'h0;
         shift <= 8'h00;
         ptr   <= REG_STATUS;
         tx    <= 8'h00;
         nack  <= 1'b0;
         oe    <= 1'b0;
         cfg   <= CFG_RESET;
         chg_off <= CHG_RESET;
      end else if (start_c) begin
         st   <= S_ADDR;   // Repeated start keeps the pointer
         cnt  <= 4'h0;
         nack <= 1'b0;
         oe   <= 1'b0;
      end else if (stop_c) begin
         st <= S_IDLE;
         oe <= 1'b0;
      end else if (scl_up) begin
         if (cnt < 4'h8) begin
            shift <= {shift[6:0], sda};
            cnt   <= cnt + 4'h1;
         end else if (cnt == 4'h9 && st == S_RDATA) begin
            nack <= sda;   // Master ends the read with a high ack
         end
      end else if (scl_dn) begin
         if (cnt == 4'h8) begin
            cnt <= 4'h9;
            case (st)
               S_ADDR: begin
                  if (addr_hit) begin
                     oe <= 1'b1;
                     st <= rx_byte[0] ? S_RDATA : S_CMD;
                     tx <= rd_val;
                  end else begin
                     st <= S_IDLE;
                  end
               end
               S_CMD: begin
                  ptr <= rx_byte;
                  oe  <= 1'b1;
                  st  <= S_WDATA;
               end
               S_WDATA: begin
                  oe <= 1'b1;
                  if (wr_cfg) begin
                     cfg     <= rx_byte[5:0];
                     chg_off <= rx_byte[CFG_CHG];
                  end
                  if (wr_rst) begin
                     cfg     <= CFG_RESET;
                     chg_off <= CHG_RESET;
                  end
               end
               S_RDATA: begin
                  oe <= 1'b0;   // Release for master ack
                  tx <= rd_val;
               end
               default: oe <= 1'b0;
            endcase
         end else if (cnt == 4'h9) begin
            cnt <= 4'h0;
            if (st == S_RDATA && !nack) begin
               oe <= ~tx[7];
               tx <= {tx[6:0], 1'b0};
            end else begin
               oe <= 1'b0;
               if (st == S_RDATA)
                  st <= S_IDLE;
            end
         end else if (st == S_RDATA && cnt != 4'h0) begin
            oe <= ~tx[7];
            tx <= {tx[6:0], 1'b0};
         end
      end
   end

   assign bus.dev_sda_oe  = oe;
   assign bus.dev_sda_out = 1'b0;

   // Supply selection, discharge mode
   logic [QW-1:0] qual_cnt;
   wire a_low2    = ~a_cmp[CMP_TH2];
   wire b_low2    = ~b_cmp[CMP_TH2];
   wire qual_done = qual_cnt == QW'(QUAL);
   wire force_ok  = ~a_low2 & ~b_low2;
   wire [1:0] auto_src = b_low2 ? SRC_A :
                         a_low2 ? SRC_B :
                         (qual_done & b_cmp[CMP_TH1H]) ? SRC_B :
                         (src == SRC_B & ~a_cmp[CMP_TH1H]) ? SRC_B : SRC_A;
   wire [1:0] next_src = adapter ? ((~a_id & ~b_id) ? SRC_AC : src) :
                         (force_ok & pwr_sel == SEL_A) ? SRC_A :
                         (force_ok & pwr_sel == SEL_B) ? SRC_B : auto_src;

   // Low-voltage time on battery A saturates at the delay
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         qual_cnt <= '0;
         src      <= SRC_A;
      end else begin
         if (a_cmp[CMP_TH1])
            qual_cnt <= '0;
         else if (!qual_done)
            qual_cnt <= qual_cnt + 1'b1;
         src <= next_src;
      end
   end

   // Analog controls from register fields
   assign supply_source_state = src;
   assign threshold_one       = cfg[CFG_TH1];
   assign threshold_two       = cfg[CFG_TH2];
   assign hysteresis_select   = cfg[CFG_HYS+1:CFG_HYS];
   assign charger_off         = chg_off;
endmodule

// ---- verilog/dbs_host.sv ----
// Host end: I2C master driven by software through AXI4-Lite registers.
// Assumes one transfer at a time; the link clock is made here by a divider.
module dbs_host
   import dbs_pkg::*;
#(
   parameter int QTR = I2C_QTR_CYCLES
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write
   input  wire logic [AXI_AW-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // AXI4-Lite read
   input  wire logic [AXI_AW-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Serial link
   dbs_if.host                    bus
);
   if (QTR < 4) $error("QTR must cover synchroniser latency");

   typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} dbs_host_state_t;

   localparam int CW = $clog2(QTR);

   dbs_host_state_t hs;
   logic [31:0]     ctrl;
   logic [CW-1:0]   qcnt;
   logic [1:0]      ph;
   logic [2:0]      seq;
   logic [3:0]      bitn;
   logic [7:0]      tx;
   logic [7:0]      rx;
   logic            nack;
   logic            scl_o;
   logic            oe;
   logic            sda1;
   logic            sda2;

   wire busy = hs != H_IDLE;

   // Write channel: address and data taken together
   wire wr_hit  = awvalid & wvalid & ~bvalid;
   wire wr_ctrl = awaddr[AXI_AW-1:2] == AXI_CTRL[AXI_AW-1:2];
   wire launch  = wr_hit & wr_ctrl & wstrb[0] & wdata[CTRL_GO] & ~busy;
   assign awready = wr_hit;
   assign wready  = wr_hit;
   assign arready = arvalid & ~rvalid;

   // Byte-lane merge into the control word
   logic [31:0] next_ctrl;
   always_comb begin
      next_ctrl = ctrl;
      for (int i = 0; i < 4; i++)
         if (wstrb[i])
            next_ctrl[8*i +: 8] = wdata[8*i +: 8];
   end

   wire [1:0] strap    = ctrl[CTRL_STRAP+1:CTRL_STRAP];
   wire       rd_mode  = ctrl[CTRL_RD];
   wire       rx_mode  = seq == 3'd5;
   wire [7:0] addr_w   = {DEV_ADDR_HI, strap, 1'b0};
   wire [7:0] addr_r   = {DEV_ADDR_HI, strap, 1'b1};
   wire       qtick    = qcnt == CW'(QTR - 1);
   wire       step_end = qtick & (ph == 2'd3);
   wire [31:0] stat_val = {16'h0000, rx, 6'h00, nack, busy};
   wire [31:0] rd_val  = (araddr[AXI_AW-1:2] == AXI_CTRL[AXI_AW-1:2]) ? ctrl : stat_val;
   wire        rd_ok   = (araddr[AXI_AW-1:2] == AXI_CTRL[AXI_AW-1:2]) |
                         (araddr[AXI_AW-1:2] == AXI_STATUS[AXI_AW-1:2]);

   // Bus responses; control writes while busy are dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl   <= 32'h0000_0000;
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
         rvalid <= 1'b0;
         rresp  <= RESP_OKAY;
         rdata  <= 32'h0000_0000;
      end else begin
         if (wr_hit) begin
            bvalid <= 1'b1;
            bresp  <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
            if (wr_ctrl && !busy)
               ctrl <= next_ctrl & ~32'h0000_0001;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
         if (arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_ok ? rd_val : 32'h0000_0000;
            rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // Returning data line passes two flip-flops
   always_ff @(posedge aclk) begin
      sda1 <= bus.sda;
      sda2 <= sda1;
   end

   // Bit engine: four quarter phases per start, bit or stop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hs    <= H_IDLE;
         qcnt  <= '0;
         ph    <= 2'd0;
         seq   <= 3'd0;
         bitn  <= 4'h0;
         tx    <= 8'h00;
         rx    <= 8'h00;
         nack  <= 1'b0;
         scl_o <= 1'b1;
         oe    <= 1'b0;   // Idle line left high
      end else if (launch) begin
         hs   <= H_START;
         seq  <= 3'd0;
         ph   <= 2'd0;
         qcnt <= '0;
         nack <= 1'b0;
      end else if (busy) begin
         qcnt <= qtick ? '0 : qcnt + 1'b1;
         if (qtick)
            ph <= ph + 2'd1;
         if (qtick) begin
            case (hs)
               H_START: begin
                  if (ph == 2'd0) oe <= 1'b0;
                  if (ph == 2'd1) scl_o <= 1'b1;
                  if (ph == 2'd2) oe <= 1'b1;
                  if (ph == 2'd3) scl_o <= 1'b0;
               end
               H_BYTE: begin
                  if (ph == 2'd0) oe <= (bitn < 4'h8) & ~rx_mode & ~tx[7];
                  if (ph == 2'd1) scl_o <= 1'b1;
                  if (ph == 2'd2) begin
                     if (bitn < 4'h8) begin
                        tx <= {tx[6:0], 1'b0};
                        if (rx_mode) rx <= {rx[6:0], sda2};
                     end else if (!rx_mode && sda2) begin
                        nack <= 1'b1;
                     end
                  end
                  if (ph == 2'd3) scl_o <= 1'b0;
               end
               H_STOP: begin
                  if (ph == 2'd0) oe <= 1'b1;
                  if (ph == 2'd1) scl_o <= 1'b1;
                  if (ph == 2'd2) oe <= 1'b0;
               end
               default: oe <= 1'b0;
            endcase
         end
         if (step_end) begin
            case (hs)
               H_START: begin
                  hs   <= H_BYTE;
                  bitn <= 4'h0;
                  seq  <= seq + 3'd1;
                  tx   <= (seq == 3'd0) ? addr_w : addr_r;
               end
               H_BYTE: begin
                  bitn <= bitn + 4'h1;
                  if (bitn == 4'h8) begin
                     bitn <= 4'h0;
                     seq  <= seq + 3'd1;
                     if (nack)
                        hs <= H_STOP;
                     else begin
                        case (seq)
                           3'd1: tx <= ctrl[CTRL_REG +: 8];
                           3'd2: begin
                              if (rd_mode) hs <= H_START;
                              else tx <= ctrl[CTRL_WDATA +: 8];
                           end
                           3'd4: hs <= H_BYTE;
                           default: hs <= H_STOP;
                        endcase
                     end
                  end
               end
               default: hs <= H_IDLE;
            endcase
         end
      end
   end

   assign bus.scl          = scl_o;
   assign bus.host_sda_oe  = oe;
   assign bus.host_sda_out = 1'b0;
endmodule

// ---- test/dbs_link_monitor.sv ----
// Link monitor: checks the two-wire link between host end and device end.
// Assumes one aclk domain and a host that idles the link clock high.
module dbs_link_monitor (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Link signals
   input wire logic scl,
   input wire logic sda,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       scl_q;
   logic       sda_q;
   logic       in_frame;
   logic       rd;
   logic       first;
   logic [3:0] bitn;
   logic       ended;

   // Conditions on the wire; bitn lags a clock rise by one aclk
   wire start    = scl && scl_q && sda_q && !sda;
   wire stop     = scl && scl_q && !sda_q && sda;
   wire rise     = scl && !scl_q;
   wire data_bit = (bitn >= 4'h1) && (bitn <= 4'h8);
   wire high     = scl && scl_q;
   // Bit one of a later byte may carry a stop or repeated start instead
   wire mid_byte = data_bit && (first || bitn != 4'h1);

   // Bit position; a start or repeated start begins a new address byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
         in_frame <= 1'h0;
         rd <= 1'h0;
         first <= 1'h1;
         bitn <= 4'h0;
         ended <= 1'h0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (start) begin
            in_frame <= 1'h1;
            first <= 1'h1;
            bitn <= 4'h0;
            ended <= 1'h0;
         end else if (stop) begin
            in_frame <= 1'h0;
         end else if (rise) begin
            bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
            if (bitn == 4'h8) ended <= sda; // High ack: only stop or restart follows
            if (bitn == 4'h9) first <= 1'h0;
            if (first && bitn == 4'h7) rd <= sda; // Direction bit
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_data_stable; high && mid_byte |-> $stable(sda); endproperty
   property p_dev_edge; $changed(dev_sda_oe) |-> !scl && !$past(scl); endproperty
   property p_host_stable; high && mid_byte |-> $stable(host_sda_oe); endproperty
   property p_idle; !in_frame |-> scl && !dev_sda_oe; endproperty
   property p_wr_ack; rise && bitn == 4'h8 && !first && !rd |-> !sda; endproperty
   property p_dev_quiet; high && data_bit && (first || !rd) |-> !dev_sda_oe; endproperty
   property p_rd_host_free;
      high && data_bit && !first && rd && !ended |-> !host_sda_oe;
   endproperty
   property p_rd_nack_free; rise && bitn == 4'h8 && !first && rd |-> !dev_sda_oe; endproperty

   a_data_stable: assert property (p_data_stable)
      else $error("sda moved while scl high in a bit");
   a_dev_edge: assert property (p_dev_edge)
      else $error("device changed sda near scl high");
   a_host_stable: assert property (p_host_stable)
      else $error("host changed sda while scl high");
   a_idle: assert property (p_idle)
      else $error("link not idle outside a frame");
   a_wr_ack: assert property (p_wr_ack)
      else $error("written byte not acknowledged");
   a_dev_quiet: assert property (p_dev_quiet)
      else $error("device drove sda in a received bit");
   a_rd_host_free: assert property (p_rd_host_free)
      else $error("host drove sda in a read bit");
   a_rd_nack_free: assert property (p_rd_nack_free)
      else $error("device held sda in the final read ack");

   c_start: cover property (start);
   c_wr_ack: cover property (rise && bitn == 4'h8 && !first && !rd && !sda);
   c_rd_byte: cover property (rise && bitn == 4'h8 && !first && rd);
endmodule

// ---- test/tb_dual_battery_select_i2c_regs.sv ----
// Bench: host end and device end joined by the link, driven over AXI4-Lite.
// Assumes the package, interface and both ends are compiled first.
module tb_dual_battery_select_i2c_regs
   import dbs_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int QL = 20; // Short qualification keeps the run brief

   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [7:0]  awaddr = 8'h0;
   logic [7:0]  araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, th1, th2, choff;
   logic [1:0]  bresp, rresp, src, hys;
   logic [31:0] rdata;
   logic [1:0]  strap = 2'h2;
   logic [1:0]  id = 2'h3; // Battery b and a id inputs
   logic        ac = 1'h0, cs_a = 1'h0, cs_b = 1'h1;
   logic [3:0]  cmp_a = 4'hf, cmp_b = 4'hf;
   int          n_errors = 0, checks = 0;

   dbs_if link ();
   dbs_device #(.QUAL(QL)) dbs_device_inst (.aclk(aclk), .aresetn(aresetn), .bus(link),
      .addr_strap_high(strap[1]), .addr_strap_low(strap[0]), .battery_a_id_input(id[0]),
      .battery_b_id_input(id[1]), .adapter_present(ac), .batt_a_cmp(cmp_a),
      .batt_b_cmp(cmp_b), .batt_a_charge_status(cs_a), .batt_b_charge_status(cs_b),
      .supply_source_state(src), .threshold_one(th1), .threshold_two(th2),
      .hysteresis_select(hys), .charger_off(choff));
   dbs_host #(.QTR(8)) dbs_host_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .bus(link));
   dbs_link_monitor dbs_link_monitor_inst (.aclk(aclk), .aresetn(aresetn), .scl(link.scl),
      .sda(link.sda), .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe));

   always #12.5 aclk = ~aclk;

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic conclude();
      if (n_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Request held until the rising edge that takes it; the answer is taken at its own edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do @(posedge aclk); while (!(awready && wready));
      awvalid <= 1'h0;
      wvalid <= 1'h0;
      do @(posedge aclk); while (bvalid !== 1'h1);
      r = bresp;
      bready <= 1'h0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge aclk); while (rvalid !== 1'h1);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask

   // One link transfer, then poll until the host is idle again
   task automatic i2c(input logic rd, input logic [1:0] hs, input logic [7:0] r, d,
                      output logic [31:0] st);
      logic [1:0] rs;
      axi_wr(AXI_CTRL, {6'h0, hs, d, r, 6'h0, rd, 1'h1}, rs);
      chk("ctrl resp", {30'h0, rs}, {30'h0, RESP_OKAY});
      do axi_rd(AXI_STATUS, st, rs); while (st[STAT_BUSY] !== 1'h0);
   endtask

   task automatic reg_rd(input logic [7:0] r, output logic [7:0] v);
      logic [31:0] st;
      i2c(1'h1, strap, r, 8'h00, st);
      v = st[STAT_RDATA +: 8];
   endtask

   task automatic step(input logic [3:0] a, b, input int n, input logic [1:0] e);
      @(posedge aclk);
      cmp_a <= a;
      cmp_b <= b;
      repeat (n) @(posedge aclk);
      #1 chk("source", {30'h0, src}, {30'h0, e});
   endtask

   function automatic logic [1:0] band(input logic [3:0] c);
      return c[CMP_FULL] ? 2'h3 : c[CMP_TH1] ? 2'h2 : c[CMP_TH2] ? 2'h1 : 2'h0;
   endfunction

   initial begin
      logic [31:0] st;
      logic [7:0]  v;
      logic [1:0]  rs;
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (6) @(posedge aclk);
      reg_rd(REG_CONFIG, v);
      chk("cfg reset", {24'h0, v}, {24'h0, cs_b, cs_a, CFG_RESET});
      for (int k = 0; k < 4; k++) begin
         strap <= 2'(k);
         i2c(1'h0, 2'(k), REG_STATUS, 8'hff, st);
         chk("ack", {31'h0, st[STAT_NACK]}, 32'h0);
         i2c(1'h0, ~2'(k), REG_STATUS, 8'hff, st);
         chk("nack", {31'h0, st[STAT_NACK]}, 32'h1);
      end
      strap <= 2'h2;
      i2c(1'h0, 2'h2, REG_CONFIG, 8'h4b, st);
      chk("cfg outs", {27'h0, choff, hys, th1, th2}, 32'h1b);
      reg_rd(REG_CONFIG, v);
      chk("cfg read", {24'h0, v}, {24'h0, cs_b, cs_a, 6'h0b});
      i2c(1'h0, strap, REG_RESET, 8'h01, st);
      chk("bad key", {27'h0, choff, hys, th1, th2}, 32'h1b);
      i2c(1'h0, strap, REG_RESET, RESET_KEY, st);
      chk("soft rst", {27'h0, choff, hys, th1, th2}, 32'h0);
      id <= 2'h1;
      cmp_a <= 4'h3;
      reg_rd(REG_STATUS, v);
      chk("status", {24'h0, v}, {24'h0, 2'h2, SRC_A, band(cmp_b), band(cmp_a)});
      id <= 2'h3;
      step(4'hf, 4'hf, 6, SRC_A);
      step(4'h0, 4'h7, 6, SRC_B);
      step(4'h7, 4'h7, 6, SRC_A);
      step(4'h1, 4'h7, QL - 4, SRC_A);
      step(4'h1, 4'h7, 10, SRC_B);
      reg_rd(REG_STATUS, v);
      chk("src b", {30'h0, v[5:4]}, {30'h0, SRC_B});
      step(4'h7, 4'h3, 6, SRC_A);
      step(4'h1, 4'h3, QL + 10, SRC_A);
      step(4'hf, 4'h0, 6, SRC_A);
      step(4'h0, 4'h1, 6, SRC_B);
      step(4'hf, 4'hf, 6, SRC_A);
      i2c(1'h0, strap, REG_CONFIG, {2'h0, SEL_B, 4'h0}, st);
      step(4'hf, 4'hf, 6, SRC_B);
      step(4'hf, 4'h0, 6, SRC_A);
      step(4'hf, 4'hf, 6, SRC_B);
      i2c(1'h0, strap, REG_CONFIG, {2'h0, SEL_A, 4'h0}, st);
      step(4'h1, 4'h7, QL + 10, SRC_A);
      @(posedge aclk);
      ac <= 1'h1;
      id <= 2'h0;
      step(4'hf, 4'hf, 6, SRC_AC);
      axi_wr(AXI_STATUS, 32'h1, rs);
      chk("ro resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
      axi_rd(8'h08, st, rs);
      chk("unmapped", st | {30'h0, rs}, {30'h0, RESP_SLVERR});
      conclude();
   end

   // Watchdog: about four times the expected run of some 15000 cycles
   initial begin
      #1500000;
      n_errors++;
      conclude();
   end
endmodule
